// *** core/pfam_pkg.sv ***
// Constants, command codes and types shared by the management-bus monitor
package pfam_pkg;

	// Clock and timing
	localparam int CLK_HZ       = 125_000_000;
	localparam int T_INIT_MS    = 15;
	localparam int INIT_CYC     = T_INIT_MS * (CLK_HZ / 1000);
	localparam int T_TICK_MS    = 1;
	localparam int MS_CYC       = T_TICK_MS * (CLK_HZ / 1000);
	localparam int T_STRETCH_US = 100;
	localparam int STRETCH_CYC  = T_STRETCH_US * (CLK_HZ / 1_000_000);

	// Register byte offsets
	localparam logic [7:0] A_CTRL     = 8'h00;
	localparam logic [7:0] A_ONDLY    = 8'h04;
	localparam logic [7:0] A_MEAS0    = 8'h08;
	localparam logic [7:0] A_STATE    = 8'h24;
	localparam logic [7:0] A_IRQ_STAT = 8'h28;
	localparam logic [7:0] A_IRQ_MASK = 8'h2C;

	// Field positions
	localparam int CTRL_SEL_BIT  = 0;
	localparam int CTRL_BASE_LSB = 8;
	localparam int IRQ_CLR       = 0;
	localparam int IRQ_ALERT     = 1;
	localparam int IRQ_STORE     = 2;
	localparam int IRQ_BUSY      = 3;
	localparam int CML_INV_BIT   = 15;

	// Reset values
	localparam logic [31:0] CTRL_RST  = 32'h0000_0000;
	localparam logic [15:0] ONDLY_RST = 16'h0005;
	localparam logic [3:0]  IRQ_RST   = 4'h0;

	// Measurement slots
	localparam int NMEAS    = 7;
	localparam int M_VIN    = 0;
	localparam int M_VOUT   = 1;
	localparam int M_IOUT   = 2;
	localparam int M_TINT   = 3;
	localparam int M_TEXT   = 4;
	localparam int M_FREQ   = 5;
	localparam int M_DUTY   = 6;

	// Bus addressing
	localparam logic [7:0] ADDR_MAX  = 8'h7E;
	localparam logic [7:0] ADDR_BAN0 = 8'h0C;
	localparam logic [7:0] ADDR_BAN1 = 8'h10;

	// Command codes
	localparam logic [7:0] C_CLEAR_FAULTS = 8'h03;
	localparam logic [7:0] C_STORE_USER   = 8'h15;
	localparam logic [7:0] C_ALERT_MASK   = 8'h1B;
	localparam logic [7:0] C_ST_BYTE      = 8'h78;
	localparam logic [7:0] C_ST_WORD      = 8'h79;
	localparam logic [7:0] C_ST_VOUT      = 8'h7A;
	localparam logic [7:0] C_ST_IOUT      = 8'h7B;
	localparam logic [7:0] C_ST_INPUT     = 8'h7C;
	localparam logic [7:0] C_ST_TEMP      = 8'h7D;
	localparam logic [7:0] C_ST_CML       = 8'h7E;
	localparam logic [7:0] C_ST_MFR       = 8'h80;
	localparam logic [7:0] C_RD_VIN       = 8'h88;
	localparam logic [7:0] C_RD_VOUT      = 8'h8B;
	localparam logic [7:0] C_RD_IOUT      = 8'h8C;
	localparam logic [7:0] C_RD_TEMP1     = 8'h8D;
	localparam logic [7:0] C_RD_DUTY      = 8'h94;
	localparam logic [7:0] C_RD_FREQ      = 8'h95;
	localparam logic [7:0] C_TEMP_SEL     = 8'hDC;

	localparam logic [1:0] RESP_OK  = 2'b00;
	localparam logic [1:0] RESP_ERR = 2'b10;

	// Fault categories, one byte each
	typedef struct packed {
		logic [7:0] vout;
		logic [7:0] iout;
		logic [7:0] vin;
		logic [7:0] temp;
		logic [7:0] cml;
		logic [7:0] mfr;
	} pfam_flt_s;

	typedef enum logic [2:0] {
		ST_IDLE  = 3'b000,
		ST_ADDR  = 3'b001,
		ST_CMD   = 3'b010,
		ST_WDATA = 3'b011,
		ST_AREAD = 3'b100,
		ST_RDATA = 3'b101,
		ST_WAIT  = 3'b110
	} pfam_state_e;

endpackage

// *** core/pfam_monitor.sv ***
// Management-bus target with fault alert, status categories and power-up sequencing
`timescale 1ns/1ps

// Function
// - Follow bus protocol; device may stretch clock
// - Set busy flag when too occupied
// - Measurements readable at any time; the bus target does not acknowledge until ready_q is set
// - Temperature source chosen by selection command
// - Alert line low on active fault
// - Alert held until clear or re-enable
// - Mask excludes faults from alert
// - Status reported per fault category
// - Ready after init time past input threshold
// - Same turn-on delay for either enable source
// - Illegal computed address falls back to 126
module pfam_monitor
	import pfam_pkg::*;
#(
	parameter int INIT_CYCLES    = INIT_CYC,
	parameter int MS_CYCLES      = MS_CYC,
	parameter int STRETCH_CYCLES = STRETCH_CYC
) (
	// Clock, reset, enable
	input  wire logic        clk,
	input  wire logic        arst_n,
	input  wire logic        ce,
	// AXI4-Lite register port
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	// Management bus pins
	input  wire logic        scl_i,
	output logic             scl_o,
	output logic             scl_oe,
	input  wire logic        sda_i,
	output logic             sda_o,
	output logic             sda_oe,
	output logic             fault_alert_line_o,
	output logic             fault_alert_line_oe,
	// Board pins
	input  wire logic        remote_onoff_pin,
	input  wire logic        vin_ok,
	input  wire logic [2:0]  addr_strap,
	// Converter core
	input  wire logic        busy,
	input  pfam_flt_s        fault_evt,
	output logic             out_en,
	output logic             power_good,
	output logic             irq
);

	// Pin synchronisers: stage one feeds stage two only
	logic [6:0] s1_q, s2_q;
	logic       scl_p_q, sda_p_q;
	wire        scl_s = s2_q[0];
	wire        sda_s = s2_q[1];
	wire        vin_s = s2_q[2];
	wire        rc_s  = s2_q[3];
	wire  [2:0] off_s = s2_q[6:4];

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			s1_q    <= 7'h7F;
			s2_q    <= 7'h7F;
			scl_p_q <= 1'b1;
			sda_p_q <= 1'b1;
		end else if (ce) begin
			s1_q    <= {addr_strap, remote_onoff_pin, vin_ok, sda_i, scl_i};
			s2_q    <= s1_q;
			scl_p_q <= scl_s;
			sda_p_q <= sda_s;
		end
	end

	wire bus_start = scl_s && scl_p_q && sda_p_q && !sda_s;
	wire bus_stop  = scl_s && scl_p_q && !sda_p_q && sda_s;
	wire scl_rise  = scl_s && !scl_p_q;
	wire scl_fall  = !scl_s && scl_p_q;

	// Registers
	logic [31:0] ctrl_q;
	logic [15:0] ondly_q;
	logic [15:0] meas_q [NMEAS];
	logic [3:0]  irq_stat_q, irq_mask_q;
	pfam_flt_s   flt_q, msk_q;
	logic        stat_busy_q, temp_sel_q, ready_q, en_rise_q, exec_q;

	function automatic logic [6:0] pfam_addr(input logic [6:0] base, input logic [2:0] off);
		logic [7:0] sum;
		sum = {1'b0, base} + {5'h00, off};
		if (sum == 8'h00 || sum > ADDR_MAX || sum == ADDR_BAN0 || sum == ADDR_BAN1)
			sum = ADDR_MAX;
		return sum[6:0];
	endfunction

	wire [6:0] my_addr = pfam_addr(ctrl_q[CTRL_BASE_LSB +: 7], off_s);

	// AXI4-Lite slave: one write and one read in flight
	logic [7:0] awaddr_q;
	logic [31:0] wdata_q;
	logic [3:0] wstrb_q;
	wire aw_hs  = s_axi_awvalid && s_axi_awready;
	wire w_hs   = s_axi_wvalid && s_axi_wready;
	wire b_hs   = s_axi_bvalid && s_axi_bready;
	wire ar_hs  = s_axi_arvalid && s_axi_arready;
	wire r_hs   = s_axi_rvalid && s_axi_rready;
	wire do_wr  = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
	wire [7:0] wm_idx  = (awaddr_q - A_MEAS0) >> 2;
	wire [7:0] rm_idx  = (s_axi_araddr - A_MEAS0) >> 2;
	wire wm_hit = awaddr_q >= A_MEAS0 && wm_idx < 8'(NMEAS);
	wire rm_hit = s_axi_araddr >= A_MEAS0 && rm_idx < 8'(NMEAS);
	wire [31:0] bmask = {{8{wstrb_q[3]}}, {8{wstrb_q[2]}}, {8{wstrb_q[1]}}, {8{wstrb_q[0]}}};
	wire wr_ctrl = do_wr && awaddr_q == A_CTRL;
	wire wr_ondly = do_wr && awaddr_q == A_ONDLY;
	wire wr_meas = do_wr && wm_hit;
	wire wr_istat = do_wr && awaddr_q == A_IRQ_STAT;
	wire wr_imask = do_wr && awaddr_q == A_IRQ_MASK;
	wire wr_ok = wr_ctrl || wr_ondly || wr_meas || wr_istat || wr_imask
		|| awaddr_q == A_STATE;
	wire [31:0] w_new = wdata_q & bmask;
	wire [3:0] w1c = wr_istat ? w_new[3:0] : 4'h0;

	wire [31:0] state_word = {16'h0000, 1'b0, my_addr, 3'h0, temp_sel_q, power_good,
		fault_alert_line_oe, out_en, ready_q};
	wire rd_ok = rm_hit || s_axi_araddr == A_CTRL || s_axi_araddr == A_ONDLY
		|| s_axi_araddr == A_STATE || s_axi_araddr == A_IRQ_STAT
		|| s_axi_araddr == A_IRQ_MASK;
	wire [31:0] rd_word =
		rm_hit                          ? {16'h0000, meas_q[rm_idx[2:0]]} :
		s_axi_araddr == A_CTRL          ? ctrl_q :
		s_axi_araddr == A_ONDLY         ? {16'h0000, ondly_q} :
		s_axi_araddr == A_STATE         ? state_word :
		s_axi_araddr == A_IRQ_STAT      ? {28'h0000_000, irq_stat_q} :
		s_axi_araddr == A_IRQ_MASK      ? {28'h0000_000, irq_mask_q} : 32'h0000_0000;

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			s_axi_awready <= 1'b1;
			s_axi_wready  <= 1'b1;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= RESP_OK;
			awaddr_q      <= 8'h00;
			wdata_q       <= 32'h0000_0000;
			wstrb_q       <= 4'h0;
		end else if (ce) begin
			if (aw_hs) begin
				s_axi_awready <= 1'b0;
				awaddr_q      <= s_axi_awaddr;
			end
			if (w_hs) begin
				s_axi_wready <= 1'b0;
				wdata_q      <= s_axi_wdata;
				wstrb_q      <= s_axi_wstrb;
			end
			if (do_wr) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= wr_ok ? RESP_OK : RESP_ERR;
			end else if (b_hs) begin
				s_axi_bvalid  <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready  <= 1'b1;
			end
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0000_0000;
			s_axi_rresp   <= RESP_OK;
		end else if (ce) begin
			if (ar_hs) begin
				s_axi_arready <= 1'b0;
				s_axi_rvalid  <= 1'b1;
				s_axi_rdata   <= rd_word;
				s_axi_rresp   <= rd_ok ? RESP_OK : RESP_ERR;
			end else if (r_hs) begin
				s_axi_rvalid  <= 1'b0;
				s_axi_arready <= 1'b1;
			end
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			ctrl_q     <= CTRL_RST;
			ondly_q    <= ONDLY_RST;
			irq_mask_q <= IRQ_RST;
			for (int i = 0; i < NMEAS; i++)
				meas_q[i] <= 16'h0000;
		end else if (ce) begin
			if (wr_ctrl)
				ctrl_q <= (ctrl_q & ~bmask) | w_new;
			if (wr_ondly)
				ondly_q <= (ondly_q & ~bmask[15:0]) | w_new[15:0];
			if (wr_imask)
				irq_mask_q <= (irq_mask_q & ~bmask[3:0]) | w_new[3:0];
			if (wr_meas)
				meas_q[wm_idx[2:0]] <= (meas_q[wm_idx[2:0]] & ~bmask[15:0]) | w_new[15:0];
		end
	end

	// Bus target state
	pfam_state_e st_q;
	logic [3:0]  bit_q;
	logic        ack_q, rd_idx_q, stretch_q;
	logic [7:0]  shreg_q, cmd_q;
	logic [7:0]  wdat_q [2];
	logic [1:0]  wr_idx_q;
	logic [$clog2(STRETCH_CYCLES)-1:0] str_cnt_q;
	logic [15:0] tx_word;

	wire addr_hit = shreg_q[7:1] == my_addr && ready_q;
	wire busy_ev  = st_q == ST_ADDR && !ack_q && bit_q == 4'h8 && scl_fall && addr_hit && busy;
	wire str_exp  = stretch_q && str_cnt_q == ($clog2(STRETCH_CYCLES))'(STRETCH_CYCLES - 1);
	wire [7:0] tx_byte = rd_idx_q ? tx_word[15:8] : tx_word[7:0];
	wire [7:0] tx_sh   = tx_byte << bit_q;

	// Reads return little-endian words; byte reads just stop after the low byte
	always_comb begin
		case (cmd_q)
			C_RD_VIN:   tx_word = meas_q[M_VIN];
			C_RD_VOUT:  tx_word = meas_q[M_VOUT];
			C_RD_IOUT:  tx_word = meas_q[M_IOUT];
			C_RD_TEMP1: tx_word = temp_sel_q ? meas_q[M_TEXT] : meas_q[M_TINT];
			C_RD_FREQ:  tx_word = meas_q[M_FREQ];
			C_RD_DUTY:  tx_word = meas_q[M_DUTY];
			C_TEMP_SEL: tx_word = {15'h0000, temp_sel_q};
			C_ST_BYTE, C_ST_WORD: tx_word = {|flt_q.vout, |flt_q.iout, |flt_q.vin,
				|flt_q.mfr, !power_good, 3'h0, stat_busy_q, !out_en, |flt_q.vout,
				|flt_q.iout, |flt_q.vin, |flt_q.temp, |flt_q.cml, 1'b0};
			C_ST_VOUT:  tx_word = {8'h00, flt_q.vout};
			C_ST_IOUT:  tx_word = {8'h00, flt_q.iout};
			C_ST_INPUT: tx_word = {8'h00, flt_q.vin};
			C_ST_TEMP:  tx_word = {8'h00, flt_q.temp};
			C_ST_CML:   tx_word = {8'h00, flt_q.cml};
			C_ST_MFR:   tx_word = {8'h00, flt_q.mfr};
			default:    tx_word = 16'hFFFF;
		endcase
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			st_q <= ST_IDLE;
			bit_q <= 4'h0;
			ack_q <= 1'b0;
			rd_idx_q <= 1'b0;
			wr_idx_q <= 2'h0;
			shreg_q <= 8'h00;
			cmd_q <= 8'h00;
			wdat_q[0] <= 8'h00;
			wdat_q[1] <= 8'h00;
			sda_oe <= 1'b0;
			scl_oe <= 1'b0;
			stretch_q <= 1'b0;
			str_cnt_q <= '0;
			exec_q <= 1'b0;
		end else if (ce) begin
			exec_q <= 1'b0;
			if (bus_start) begin
				st_q <= ST_ADDR;
				bit_q <= 4'h0;
				ack_q <= 1'b0;
				rd_idx_q <= 1'b0;
				wr_idx_q <= 2'h0;
				sda_oe <= 1'b0;
			end else if (bus_stop) begin
				exec_q <= st_q == ST_WDATA;
				st_q <= ST_IDLE;
				ack_q <= 1'b0;
				sda_oe <= 1'b0;
			end else if (stretch_q) begin
				// Bounded so a stuck core cannot hang the bus
				str_cnt_q <= str_cnt_q + 1'b1;
				if (!busy || str_exp) begin
					stretch_q <= 1'b0;
					scl_oe <= 1'b0;
				end
			end else if (scl_rise && st_q != ST_IDLE && st_q != ST_WAIT) begin
				if (!ack_q && bit_q != 4'h8) begin
					shreg_q <= {shreg_q[6:0], sda_s};
					bit_q <= bit_q + 1'b1;
				end else if (ack_q && st_q == ST_RDATA) begin
					if (sda_s)
						st_q <= ST_WAIT;
					else
						rd_idx_q <= !rd_idx_q;
				end
			end else if (scl_fall && st_q != ST_IDLE && st_q != ST_WAIT) begin
				if (!ack_q && bit_q == 4'h8) begin
					ack_q <= 1'b1;
					case (st_q)
						ST_ADDR: begin
							sda_oe <= addr_hit;
							st_q <= !addr_hit ? ST_WAIT : shreg_q[0] ? ST_AREAD : ST_CMD;
						end
						ST_CMD: begin
							cmd_q <= shreg_q;
							sda_oe <= 1'b1;
							st_q <= ST_WDATA;
						end
						ST_WDATA: begin
							if (wr_idx_q < 2'h2)
								wdat_q[wr_idx_q[0]] <= shreg_q;
							if (wr_idx_q != 2'h3)
								wr_idx_q <= wr_idx_q + 1'b1;
							sda_oe <= 1'b1;
						end
						default: sda_oe <= 1'b0;
					endcase
				end else if (ack_q) begin
					ack_q <= 1'b0;
					bit_q <= 4'h0;
					if (st_q == ST_AREAD)
						st_q <= ST_RDATA;
					sda_oe <= (st_q == ST_AREAD || st_q == ST_RDATA) && !tx_byte[7];
					if (busy) begin
						stretch_q <= 1'b1;
						scl_oe <= 1'b1;
						str_cnt_q <= '0;
					end
				end else if (st_q == ST_RDATA && bit_q != 4'h8) begin
					sda_oe <= !tx_sh[7];
				end
			end
		end
	end

	// Write commands act at the stop; a write stopped with the wrong byte count sets the CML invalid-command fault
	wire clr_cmd   = exec_q && cmd_q == C_CLEAR_FAULTS && wr_idx_q == 2'h0;
	wire store_cmd = exec_q && cmd_q == C_STORE_USER && wr_idx_q == 2'h0;
	wire mask_cmd  = exec_q && cmd_q == C_ALERT_MASK && wr_idx_q == 2'h2;
	wire tsel_cmd  = exec_q && cmd_q == C_TEMP_SEL && wr_idx_q == 2'h1;
	wire inv_cmd   = exec_q && !(clr_cmd || store_cmd || mask_cmd || tsel_cmd);
	wire clr_all   = clr_cmd || en_rise_q;
	wire [47:0] flt_set = fault_evt | (48'h0000_0000_0001 << CML_INV_BIT) & {48{inv_cmd}};
	wire [47:0] active = flt_q & ~msk_q;

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			flt_q <= '0;
			msk_q <= '0;
			stat_busy_q <= 1'b0;
			temp_sel_q <= 1'b0;
			fault_alert_line_oe <= 1'b0;
		end else if (ce) begin
			// A new event in the clearing cycle survives the clear
			flt_q <= (clr_all ? 48'h0000_0000_0000 : flt_q) | flt_set;
			stat_busy_q <= (!clr_all && stat_busy_q) || busy_ev || str_exp;
			fault_alert_line_oe <= |active;
			if (tsel_cmd)
				temp_sel_q <= wdat_q[0][0];
			if (mask_cmd) begin
				case (wdat_q[0])
					C_ST_VOUT:  msk_q.vout <= wdat_q[1];
					C_ST_IOUT:  msk_q.iout <= wdat_q[1];
					C_ST_INPUT: msk_q.vin  <= wdat_q[1];
					C_ST_TEMP:  msk_q.temp <= wdat_q[1];
					C_ST_CML:   msk_q.cml  <= wdat_q[1];
					C_ST_MFR:   msk_q.mfr  <= wdat_q[1];
					default:    msk_q.mfr  <= msk_q.mfr;
				endcase
			end
		end
	end

	// Power-up readiness and turn-on delay
	logic [$clog2(INIT_CYCLES)-1:0] init_cnt_q;
	logic [$clog2(MS_CYCLES)-1:0]   pre_q;
	logic [15:0]                    dly_q;
	wire en_req = ready_q && (ctrl_q[CTRL_SEL_BIT] ? !rc_s : vin_s);
	wire tick   = pre_q == ($clog2(MS_CYCLES))'(MS_CYCLES - 1);

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			init_cnt_q <= '0;
			ready_q <= 1'b0;
			pre_q <= '0;
			dly_q <= 16'h0000;
			out_en <= 1'b0;
			en_rise_q <= 1'b0;
			power_good <= 1'b0;
		end else if (ce) begin
			if (!vin_s && !ready_q)
				init_cnt_q <= '0;
			else if (!ready_q && init_cnt_q == ($clog2(INIT_CYCLES))'(INIT_CYCLES - 1))
				ready_q <= 1'b1;
			else if (!ready_q)
				init_cnt_q <= init_cnt_q + 1'b1;
			en_rise_q <= 1'b0;
			if (!en_req) begin
				out_en <= 1'b0;
				pre_q <= '0;
				dly_q <= 16'h0000;
			end else if (!out_en) begin
				if (dly_q == ondly_q) begin
					out_en <= 1'b1;
					en_rise_q <= 1'b1;
				end else if (tick) begin
					pre_q <= '0;
					dly_q <= dly_q + 1'b1;
				end else begin
					pre_q <= pre_q + 1'b1;
				end
			end
			power_good <= out_en && !(|flt_q);
		end
	end

	// Interrupts toward local software
	wire [3:0] irq_ev = {stat_busy_q && !clr_all ? 1'b0 : busy_ev, store_cmd,
		|active && !fault_alert_line_oe, clr_cmd};

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			irq_stat_q <= IRQ_RST;
			irq <= 1'b0;
			scl_o <= 1'b0;
			sda_o <= 1'b0;
			fault_alert_line_o <= 1'b0;
		end else if (ce) begin
			irq_stat_q <= (irq_stat_q & ~w1c) | irq_ev;
			irq <= |(irq_stat_q & irq_mask_q);
		end
	end

	a_alert_follows: assert property (@(posedge clk) disable iff (!arst_n)
		ce && |active |=> fault_alert_line_oe) else $error("alert not driven on fault");
	a_alert_held: assert property (@(posedge clk) disable iff (!arst_n)
		$fell(fault_alert_line_oe) |-> $past(clr_all, 2)) else $error("alert dropped early");
	a_mask_gates: assert property (@(posedge clk) disable iff (!arst_n)
		fault_alert_line_oe |-> $past(|(flt_q & ~msk_q))) else $error("masked alert");
	a_busy_flag_set: assert property (@(posedge clk) disable iff (!arst_n)
		ce && busy_ev |=> stat_busy_q) else $error("busy flag missing");
	a_addr_legal: assert property (@(posedge clk) disable iff (!arst_n)
		my_addr != 7'h00 && my_addr != ADDR_BAN0[6:0] && my_addr != ADDR_BAN1[6:0]
		&& my_addr <= ADDR_MAX[6:0]) else $error("illegal bus address");
	a_init_time: assert property (@(posedge clk) disable iff (!arst_n)
		$rose(ready_q) |-> $past(init_cnt_q) == ($clog2(INIT_CYCLES))'(INIT_CYCLES - 1))
		else $error("ready before init time");
	a_on_delay: assert property (@(posedge clk) disable iff (!arst_n)
		$rose(out_en) |-> $past(dly_q) == ondly_q && $past(en_req))
		else $error("turn-on delay wrong");
	a_foreign_quiet: assert property (@(posedge clk) disable iff (!arst_n)
		st_q == ST_WAIT && $past(st_q) == ST_WAIT |-> !sda_oe)
		else $error("drove bus for foreign address");

endmodule

// *** verification/pfam_host.sv ***
// Management-bus host model: open-drain pull-downs, tolerant of clock stretching
`timescale 1ns/1ps
module pfam_host
	import pfam_pkg::*;
#(
	// Store wait scaled to the bench's shortened millisecond (5 x 10 cycles x 8 ns)
	parameter realtime T_STORE = 400.0
) (
	// Wire levels
	input  wire logic scl,
	input  wire logic sda,
	// Pull-downs, high while the host holds the wire low
	output logic      scl_dn,
	output logic      sda_dn
);
	localparam realtime Q = 31.25;
	logic ok;
	// Counts clock releases that never came, so the bench can fail on a stuck target
	int   stuck;
	initial begin
		scl_dn = 1'b0;
		sda_dn = 1'b0;
		stuck = 0;
	end
	// Bounded, so a target that never lets go cannot hang the run
	task automatic rise();
		scl_dn = 1'b0;
		for (int n = 0; n < 20000 && !scl; n++) #1;
		if (!scl) stuck++;
		#Q;
	endtask
	// One clock period; b0 high with b1 low makes a start condition, b0 low with b1 high a stop
	task automatic slot(input logic b0, input logic b1, output logic rv);
		sda_dn = !b0;
		#Q;
		rise();
		rv = sda;
		sda_dn = !b1;
		#Q;
		scl_dn = 1'b1;
		#Q;
	endtask
	task automatic wr_byte(input logic [7:0] d);
		logic rv;
		for (int i = 7; i >= 0; i--)
			slot(d[i], d[i], rv);
		slot(1'b1, 1'b1, rv);
		ok = ok & !rv;
	endtask
	// No packet error code: the target neither sends nor checks one
	task automatic xfer(input logic [6:0] a, input logic [7:0] cmd, input int nw,
		input logic [15:0] wd, input int nr, output logic [15:0] rd, output logic ack);
		logic rv;
		logic h;
		ok = 1'b1;
		rd = 16'h0000;
		slot(1'b1, 1'b0, rv);
		wr_byte({a, 1'b0});
		wr_byte(cmd);
		for (int k = 0; k < nw; k++)
			wr_byte(wd[8 * k +: 8]);
		if (nr > 0) begin
			slot(1'b1, 1'b0, rv);
			wr_byte({a, 1'b1});
		end
		for (int k = 0; k < 9 * nr; k++) begin
			h = k % 9 < 8 || k == 9 * nr - 1;
			slot(h, h, rv);
			if (k % 9 < 8)
				rd[8 * (k / 9) + 7 - k % 9] = rv;
		end
		sda_dn = 1'b1;
		#Q;
		rise();
		sda_dn = 1'b0;
		ack = ok;
		#1300;
		if (cmd == C_STORE_USER)
			#T_STORE;
	endtask
endmodule

// *** verification/test_pfam_monitor.sv ***
// Bench: monitor against the host model and integer expectations
`timescale 1ns/1ps
module test_pfam_monitor
	import pfam_pkg::*;
;
	localparam int MSC  = 10;
	localparam int INIT = 50;
	localparam logic [7:0] RCMD [6] = '{C_RD_VIN, C_RD_VOUT, C_RD_IOUT,
		C_RD_TEMP1, C_RD_FREQ, C_RD_DUTY};
	localparam int SLOT [6] = '{M_VIN, M_VOUT, M_IOUT, M_TINT, M_FREQ, M_DUTY};
	logic        clk, arst_n, ce, busy, vin_ok, remote_onoff_pin, h_scl, h_sda;
	logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
	logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic [7:0]  s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, q;
	logic [3:0]  s_axi_wstrb;
	logic [2:0]  addr_strap;
	logic [1:0]  s_axi_bresp, s_axi_rresp, r;
	logic        scl_o, scl_oe, sda_o, sda_oe, fault_alert_line_o, fault_alert_line_oe;
	logic        out_en, power_good, irq;
	pfam_flt_s   fault_evt;
	int          err_count, checked, meas[NMEAS];
	// Pull-ups: a wire nobody pulls down reads high
	wire         scl_i = !(scl_oe | h_scl);
	wire         sda_i = !(sda_oe | h_sda);
	wire         alert_on = fault_alert_line_oe;
	pfam_monitor #(.INIT_CYCLES(INIT), .MS_CYCLES(MSC), .STRETCH_CYCLES(20)) dut_u (.*);
	pfam_host host_u (.scl(scl_i), .sda(sda_i), .scl_dn(h_scl), .sda_dn(h_sda));
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		checked++;
		if (got !== exp) begin
			err_count++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic conclude();
		$display("checked %0d mismatches %0d", checked, err_count);
		if (err_count == 0 && checked > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task automatic hang();
		err_count++;
		conclude();
	endtask
	// One register access; every channel held until its own ready
	task automatic axi(input bit wr, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge clk);
		s_axi_awaddr <= a;
		s_axi_araddr <= a;
		s_axi_wdata <= d;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {3{wr}};
		{s_axi_arvalid, s_axi_rready} <= {2{!wr}};
		for (n = 0; n < 50; n++) begin
			@(posedge clk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
			if (wr ? s_axi_bvalid : s_axi_rvalid) break;
		end
		q = s_axi_rdata;
		r = wr ? s_axi_bresp : s_axi_rresp;
		{s_axi_bready, s_axi_rready} <= 2'b00;
		if (n == 50) hang();
	endtask
	task automatic wait_en(input logic v, output int t);
		for (t = 0; t < 400 && out_en !== v; t++) @(posedge clk);
		if (t == 400) hang();
	endtask
	task automatic pulse(input int sh, output logic [7:0] b);
		b = 8'h01 << ($urandom % 8);
		@(posedge clk);
		fault_evt <= pfam_flt_s'(48'(b) << sh);
		@(posedge clk);
		fault_evt <= '0;
		repeat (3) @(posedge clk);
	endtask
	initial begin
		logic [15:0] w;
		logic [7:0]  b;
		logic [6:0]  da;
		logic        ok;
		int          t;
		{err_count, checked} = '0;
		{arst_n, busy, vin_ok, addr_strap, fault_evt} = '0;
		{ce, remote_onoff_pin} = 2'b11;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = {48'h0, 4'hF};
		void'($urandom(4681));
		repeat (20) @(posedge clk);
		arst_n <= 1'b1;
		axi(0, A_CTRL, 0);
		chk("ctrl", CTRL_RST, q);
		axi(0, A_ONDLY, 0);
		chk("ondly", 32'(ONDLY_RST), q);
		axi(0, A_IRQ_MASK, 0);
		chk("irq mask", 32'(IRQ_RST), q);
		axi(1, 8'hF0, 0);
		chk("bresp", 32'(RESP_ERR), 32'(r));
		axi(0, 8'hF0, 0);
		chk("rresp", 32'(RESP_ERR), 32'(r));
		chk("unmapped rdata", 0, q);
		$display("test registers done");
		axi(1, A_CTRL, 32'h0000_0A00);
		addr_strap <= 3'd2;
		t = 10 + 2;
		da = (t < 1 || t > 126 || t == 12 || t == 16) ? 7'd126 : 7'(t);
		for (int i = 0; i < NMEAS; i++) begin
			meas[i] = $urandom % 65536;
			axi(1, 8'(A_MEAS0 + 4 * i), 32'(meas[i]));
		end
		host_u.xfer(da, C_RD_VIN, 0, 0, 2, w, ok);
		chk("early ack", 0, 32'(ok));
		@(posedge clk);
		vin_ok <= 1'b1;
		wait_en(1'b1, t);
		chk("vin delay", 1, 32'(t > INIT + 4 * MSC && t < INIT + 5 * MSC + 9));
		axi(0, A_STATE, 0);
		chk("address", 32'(da), 32'(q[14:8]));
		chk("power good", 1, 32'(power_good));
		$display("test power-up done");
		for (int i = 0; i < 6; i++) begin
			host_u.xfer(da, RCMD[i], 0, 0, 2, w, ok);
			chk("measure", 32'(meas[SLOT[i]]), 32'(w));
		end
		host_u.xfer(da, C_TEMP_SEL, 1, 1, 0, w, ok);
		host_u.xfer(da, C_RD_TEMP1, 0, 0, 2, w, ok);
		chk("ext temp", 32'(meas[M_TEXT]), 32'(w));
		host_u.xfer(7'd10, C_RD_VIN, 0, 0, 2, w, ok);
		chk("foreign ack", 0, 32'(ok));
		$display("test monitoring done");
		axi(1, A_IRQ_MASK, 32'(1 << IRQ_ALERT));
		pulse(40, b);
		chk("alert", 1, 32'(alert_on));
		chk("irq", 1, 32'(irq));
		host_u.xfer(da, C_ST_VOUT, 0, 0, 1, w, ok);
		chk("status vout", 32'(b), 32'(w));
		host_u.xfer(da, C_CLEAR_FAULTS, 0, 0, 0, w, ok);
		chk("alert clear", 0, 32'(alert_on));
		axi(1, A_IRQ_STAT, 32'h0000_000F);
		repeat (2) @(posedge clk);
		chk("irq clear", 0, 32'(irq));
		host_u.xfer(da, C_ALERT_MASK, 2, {8'hFF, C_ST_VOUT}, 0, w, ok);
		pulse(40, b);
		chk("masked", 0, 32'(alert_on));
		$display("test alert done");
		@(posedge clk);
		busy <= 1'b1;
		host_u.xfer(da, C_RD_VIN, 0, 0, 2, w, ok);
		@(posedge clk);
		busy <= 1'b0;
		host_u.xfer(da, C_ST_BYTE, 0, 0, 1, w, ok);
		chk("busy bit", 1, 32'(w[7]));
		axi(0, A_IRQ_STAT, 0);
		chk("busy event", 1, 32'(q[IRQ_BUSY]));
		$display("test busy done");
		pulse(32, b);
		chk("alert", 1, 32'(alert_on));
		t = 1 + $urandom % 4;
		axi(1, A_ONDLY, 32'(t));
		axi(1, A_CTRL, 32'h0000_0A01);
		b = 8'(t);
		wait_en(1'b0, t);
		@(posedge clk);
		remote_onoff_pin <= 1'b0;
		wait_en(1'b1, t);
		chk("pin delay", 1, 32'(t > (b - 1) * MSC && t < b * MSC + 9));
		repeat (3) @(posedge clk);
		chk("re-enable", 0, 32'(alert_on));
		$display("test remote done");
		// A fault pulse while the enable is low must leave no trace
		ce <= 1'b0;
		pulse(24, b);
		ce <= 1'b1;
		chk("frozen", 0, 32'(alert_on));
		host_u.xfer(da, C_STORE_USER, 0, 0, 0, w, ok);
		chk("store ack", 1, 32'(ok));
		axi(0, A_IRQ_STAT, 0);
		chk("store event", 1, 32'(q[IRQ_STORE]));
		// An unknown write command is a communication fault
		host_u.xfer(da, 8'hA5, 0, 0, 0, w, ok);
		host_u.xfer(da, C_ST_CML, 0, 0, 1, w, ok);
		chk("status cml", 32'h0000_0080, 32'(w));
		host_u.xfer(da, C_ST_WORD, 0, 0, 2, w, ok);
		chk("status word", 32'h0000_0802, 32'(w));
		chk("cml alert", 1, 32'(alert_on));
		chk("power lost", 0, 32'(power_good));
		chk("pin levels", 0, 32'({scl_o, sda_o, fault_alert_line_o}));
		chk("stretch limit", 0, 32'(host_u.stuck));
		$display("test store done");
		conclude();
	end
endmodule
